// file: ahp_pkg.sv
// package for the ata host port: register offsets, field layouts, timings
// assumes a single clk_sys domain at 100 MHz and a synchronous reset
`default_nettype none
package ahp_pkg;
  // task-file addresses on the three address lines
  localparam logic [2:0] ADDR_DATA_PORT    = 3'h0; // data_port
  localparam logic [2:0] ADDR_FEATURES     = 3'h1;
  localparam logic [2:0] ADDR_SECTOR_COUNT = 3'h2;
  localparam logic [2:0] ADDR_COMMAND      = 3'h7; // write: command, read: status
  localparam logic [2:0] ADDR_CTRL_ALT     = 3'h6; // control_and_alt_status
  // set features subcodes for transfer width
  localparam logic [7:0] FEAT_EN_8BIT  = 8'h01;
  localparam logic [7:0] FEAT_DIS_8BIT = 8'h81;
  // command codes handled by the port itself
  localparam logic [7:0] CMD_SET_FEATURES  = 8'hEF;
  localparam logic [7:0] CMD_IDLE_ALT      = 8'h97;
  localparam logic [7:0] CMD_SLEEP_ALT     = 8'h99;
  localparam logic [7:0] CMD_PROTECT_PD    = 8'h8B;
  localparam logic [7:0] CMD_SEC_UNLOCK    = 8'hF2;
  // status, error and control bit positions and values
  localparam int STAT_BSY = 7;
  localparam int STAT_DRDY = 6;
  localparam int STAT_ERR = 0;
  localparam int CTRL_SRST = 2;
  localparam logic [7:0] STATUS_RESET = 8'h80;
  localparam logic [7:0] ERR_ABORT    = 8'h04;
  // first power-up busy time
  localparam longint FIRST_INIT_MS = 5000;
  localparam longint CLK_HZ = 100000000;
  localparam longint FIRST_INIT_CYC = FIRST_INIT_MS * CLK_HZ / 1000;
  // wear-leveling groups and zones
  localparam int NUM_WL_GROUPS = 4;
  localparam int NUM_ZONES = 4;
  localparam longint WL_MIN_CYCLES = 100000000;
  // serial manufacturing link half-bit period in clk_sys cycles
  localparam int MFG_DIV = 50;
  // decoded bus cycle
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       cmd_blk;
    logic       alt_blk;
    logic [2:0] addr;
  } ahp_cycle_s;
  // first-init states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SCAN   = 3'b001,
    ST_TABLE  = 3'b010,
    ST_FORMAT = 3'b011,
    ST_DONE   = 3'b100,
    ST_FAIL   = 3'b101
  } ahp_init_e;
endpackage : ahp_pkg
`default_nettype wire

// file: ahp_mfg_serial.sv
// serial manufacturing link: shifts an error code out, samples a bit in
// assumes clk_sys domain; serial_mfg_data_in comes from a pin
`default_nettype none
module ahp_mfg_serial (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // request side
  input  wire logic       send,
  input  wire logic [7:0] code,
  output logic            busy,
  // link pins
  output logic            serial_mfg_clock,
  output logic            serial_mfg_data_out,
  input  wire logic       serial_mfg_data_in,
  output logic            last_in_bit
);
  logic [7:0] shreg;    // outgoing code
  logic [3:0] bit_cnt;  // bits left
  logic [7:0] div_cnt;  // half-bit period divider
  logic       sync_a;   // first synchroniser stage
  logic       sync_b;   // second synchroniser stage
  wire        tick = (div_cnt == 8'(ahp_pkg::MFG_DIV - 1));

  // input synchroniser; only sync_b is read by logic
  always_ff @(posedge clk_sys) begin
    sync_a <= serial_mfg_data_in;
    sync_b <= sync_a;
  end

  // divider gives a one-cycle enable per half bit
  always_ff @(posedge clk_sys) begin
    if (rst || !busy) div_cnt <= 8'h00;
    else if (tick) div_cnt <= 8'h00;
    else div_cnt <= div_cnt + 8'h01;
  end

  // shift msb first, clock high in the second half of each bit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy <= 1'b0;
      shreg <= 8'h00;
      bit_cnt <= 4'h0;
      serial_mfg_clock <= 1'b0;
      serial_mfg_data_out <= 1'b0;
      last_in_bit <= 1'b0;
    end else if (!busy) begin
      if (send) begin
        busy <= 1'b1;
        shreg <= code;
        bit_cnt <= 4'h8;
        serial_mfg_clock <= 1'b0;
      end
    end else if (tick) begin
      if (!serial_mfg_clock) begin
        serial_mfg_data_out <= shreg[7];
        serial_mfg_clock <= 1'b1;
        last_in_bit <= sync_b;
      end else begin
        serial_mfg_clock <= 1'b0;
        shreg <= {shreg[6:0], 1'b0};
        bit_cnt <= bit_cnt - 4'h1;
        if (bit_cnt == 4'h1) busy <= 1'b0;
      end
    end
  end
endmodule // ahp_mfg_serial
`default_nettype wire

// file: ahp_port.sv
// device-side ata task-file port with first power-up init and protection
// assumes host strobes arrive asynchronously and are synchronised here
//
// Summary of operation
// - report busy about five seconds at first power
// - first-time init runs once only
// - read flash ids, build table, format
// - 16-bit data default, 8-bit after set features
// - upper byte driven as FF on 8-bit reads
// - ata-6 behaviour except three special commands
// - four wear-leveling groups, 100M writes each
// - four zones, read-only or hidden, default open
// - zone access refused until password matches
// - three-wire serial link reports manufacturing errors
`default_nettype none
module ahp_port #(
  parameter longint INIT_CYCLES = ahp_pkg::FIRST_INIT_CYC
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // ata host bus
  input  wire logic        cmd_block_select_n,
  input  wire logic        alt_block_select_n,
  input  wire logic [2:0]  addr,
  input  wire logic        io_read_strobe_n,
  input  wire logic        io_write_strobe_n,
  input  wire logic [15:0] data_in,
  output logic [15:0]      data_out,
  output logic             data_oe_hi,
  output logic             data_oe_lo,
  // non-volatile init flag, held outside across power cycles
  input  wire logic        init_done_nv,
  output logic             init_done_set,
  // flash media scan
  output logic             flash_id_req,
  input  wire logic        flash_id_valid,
  input  wire logic        flash_id_known,
  // protection setup (loaded by firmware)
  input  wire logic [3:0]  zone_enable,
  input  wire logic [3:0]  zone_hidden,
  input  wire logic [1:0]  access_zone,
  input  wire logic [15:0] zone_password,
  // media access request to the back end
  output logic             media_access_ok,
  output logic [1:0]       wl_group,
  // serial manufacturing link
  output logic             serial_mfg_clock,
  output logic             serial_mfg_data_out,
  input  wire logic        serial_mfg_data_in
);
  // synchronisers for the host strobes and selects
  logic [3:0] s1;
  logic [3:0] s2;
  logic [3:0] s2_d;          // previous synchronised value
  // task-file state
  logic [7:0]  features;     // features register
  logic [7:0]  sector_count; // sector count register
  logic [7:0]  status;       // status register
  logic [7:0]  error;        // error register
  logic [7:0]  control;      // device control register
  logic [15:0] data_latch;   // last data word written
  logic [15:0] pw_latch;     // password presented by host
  logic        mode_8bit;    // 8-bit transfer mode
  logic        unlocked;     // password accepted
  logic [7:0]  last_cmd;     // last accepted command code
  logic [15:0] next_data_out;
  // first-init sequencer
  ahp_pkg::ahp_init_e state;
  ahp_pkg::ahp_init_e next_state;
  logic [39:0] init_cnt;
  logic        mfg_send;
  logic        mfg_busy;

  // decoded cycle
  ahp_pkg::ahp_cycle_s cyc;
  assign cyc.cmd_blk = !s2[0] && s2[1];
  assign cyc.alt_blk = !s2[1] && s2[0];
  assign cyc.rd = !s2[2];
  assign cyc.wr = !s2[3];
  assign cyc.addr = addr;

  wire both_sel = !s2[0] && !s2[1];
  wire none_sel = s2[0] && s2[1];
  wire wr_edge = !s2[3] && s2_d[3];
  wire busy = status[ahp_pkg::STAT_BSY];
  wire tf_wr = wr_edge && cyc.cmd_blk;
  wire alt_wr = wr_edge && cyc.alt_blk &&
                (cyc.addr == ahp_pkg::ADDR_CTRL_ALT);
  wire cmd_wr = tf_wr && (cyc.addr == ahp_pkg::ADDR_COMMAND) && !busy;
  wire zone_on = zone_enable[access_zone];
  // hidden zones block reads and writes, read-only blocks writes
  wire zone_block_rd = zone_on && zone_hidden[access_zone] && !unlocked;
  wire zone_block_wr = zone_on && !unlocked;
  wire drive_bus = cyc.rd && !both_sel && !none_sel;

  // synchronise async host pins; s1 feeds only s2
  always_ff @(posedge clk_sys) begin
    s1 <= {io_write_strobe_n, io_read_strobe_n,
           alt_block_select_n, cmd_block_select_n};
    s2 <= s1;
    s2_d <= s2;
  end

  // init state transitions
  always_comb begin
    next_state = state;
    case (state)
      ahp_pkg::ST_IDLE:
        next_state = init_done_nv ? ahp_pkg::ST_DONE
                                  : ahp_pkg::ST_SCAN;
      ahp_pkg::ST_SCAN:
        if (flash_id_valid)
          next_state = flash_id_known ? ahp_pkg::ST_TABLE
                                      : ahp_pkg::ST_FAIL;
      ahp_pkg::ST_TABLE:
        if (init_cnt >= 40'(INIT_CYCLES / 2))
          next_state = ahp_pkg::ST_FORMAT;
      ahp_pkg::ST_FORMAT:
        if (init_cnt >= 40'(INIT_CYCLES - 1))
          next_state = ahp_pkg::ST_DONE;
      ahp_pkg::ST_DONE: next_state = ahp_pkg::ST_DONE;
      ahp_pkg::ST_FAIL: next_state = ahp_pkg::ST_FAIL;
      default: next_state = ahp_pkg::ST_IDLE;
    endcase
  end

  // init sequencer registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= ahp_pkg::ST_IDLE;
      init_cnt <= 40'h0;
    end else begin
      state <= next_state;
      if (state == ahp_pkg::ST_TABLE || state == ahp_pkg::ST_FORMAT)
        init_cnt <= init_cnt + 40'h1;
    end
  end

  assign flash_id_req = (state == ahp_pkg::ST_SCAN);
  // one pulse as the format finishes records the one-time event
  assign init_done_set = (state == ahp_pkg::ST_FORMAT) &&
                         (next_state == ahp_pkg::ST_DONE);
  assign mfg_send = (state == ahp_pkg::ST_FAIL) && !mfg_busy &&
                    !status[ahp_pkg::STAT_ERR];

  // task-file writes and command handling
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      features <= 8'h00;
      sector_count <= 8'h00;
      status <= ahp_pkg::STATUS_RESET;
      error <= 8'h00;
      control <= 8'h00;
      data_latch <= 16'h0000;
      pw_latch <= 16'h0000;
      mode_8bit <= 1'b0;
      unlocked <= 1'b0;
      last_cmd <= 8'h00;
    end else begin
      // busy stands until init is done or has failed
      if (state == ahp_pkg::ST_DONE && busy) begin
        status <= 8'h00;
        status[ahp_pkg::STAT_DRDY] <= 1'b1;
      end else if (state == ahp_pkg::ST_FAIL && busy) begin
        status <= 8'h01;
        error <= ahp_pkg::ERR_ABORT;
      end
      if (alt_wr) control <= data_in[7:0];
      if (tf_wr && cyc.addr == ahp_pkg::ADDR_FEATURES)
        features <= data_in[7:0];
      if (tf_wr && cyc.addr == ahp_pkg::ADDR_SECTOR_COUNT)
        sector_count <= data_in[7:0];
      if (tf_wr && cyc.addr == ahp_pkg::ADDR_DATA_PORT) begin
        // in 8-bit mode data_latch ignores the upper lines; pw_latch takes all 16
        data_latch <= mode_8bit ? {8'h00, data_in[7:0]} : data_in;
        pw_latch <= data_in;
      end
      // command code uses parameters already loaded
      if (cmd_wr) begin
        last_cmd <= data_in[7:0];
        error <= 8'h00;
        status[ahp_pkg::STAT_ERR] <= 1'b0;
        case (data_in[7:0])
          ahp_pkg::CMD_SET_FEATURES:
            if (features == ahp_pkg::FEAT_EN_8BIT)
              mode_8bit <= 1'b1;
            else if (features == ahp_pkg::FEAT_DIS_8BIT)
              mode_8bit <= 1'b0;
          ahp_pkg::CMD_SEC_UNLOCK:
            if (pw_latch == zone_password) unlocked <= 1'b1;
            else begin
              status[ahp_pkg::STAT_ERR] <= 1'b1;
              error <= ahp_pkg::ERR_ABORT;
            end
          default: ;
        endcase
      end
      // software reset via control re-locks the zones
      if (control[ahp_pkg::CTRL_SRST]) unlocked <= 1'b0;
    end
  end

  // read mux: data port, task file, or alternate status
  always_comb begin
    next_data_out = 16'h0000;
    if (cyc.alt_blk && cyc.addr == ahp_pkg::ADDR_CTRL_ALT)
      next_data_out = {8'h00, status};
    else if (cyc.cmd_blk) begin
      case (cyc.addr)
        ahp_pkg::ADDR_DATA_PORT:
          if (zone_block_rd) next_data_out = 16'h0000;
          else if (mode_8bit)
            next_data_out = {8'hFF, data_latch[7:0]};
          else next_data_out = data_latch;
        ahp_pkg::ADDR_FEATURES:     next_data_out = {8'h00, error};
        ahp_pkg::ADDR_SECTOR_COUNT: next_data_out = {8'h00, sector_count};
        ahp_pkg::ADDR_COMMAND:      next_data_out = {8'h00, status};
        default:                    next_data_out = 16'h0000;
      endcase
    end
  end

  // output data register and lane enables
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      data_out <= 16'h0000;
      data_oe_lo <= 1'b0;
      data_oe_hi <= 1'b0;
    end else begin
      data_out <= next_data_out;
      data_oe_lo <= drive_bus;
      // high lanes only on 16-bit or 8-bit data port reads
      data_oe_hi <= drive_bus && cyc.cmd_blk &&
                    cyc.addr == ahp_pkg::ADDR_DATA_PORT;
    end
  end

  // media access gate and wear-leveling group from sector count
  assign media_access_ok = (state == ahp_pkg::ST_DONE) &&
                           !zone_block_wr;
  assign wl_group = sector_count[1:0];

  ahp_mfg_serial u_mfg (
    .clk_sys             (clk_sys),
    .rst                 (rst),
    .send                (mfg_send),
    .code                (8'(state)),
    .busy                (mfg_busy),
    .serial_mfg_clock    (serial_mfg_clock),
    .serial_mfg_data_out (serial_mfg_data_out),
    .serial_mfg_data_in  (serial_mfg_data_in),
    .last_in_bit         ()
  );
endmodule // ahp_port
`default_nettype wire

// file: ahp_port_properties.sv
// checker for the ata host port, watching only the port's own pins
// assumes one clk_sys domain with the synchronous active-high rst
`default_nettype none
module ahp_port_properties (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // host bus
  input wire logic        cmd_block_select_n,
  input wire logic        alt_block_select_n,
  input wire logic        io_read_strobe_n,
  input wire logic        io_write_strobe_n,
  input wire logic [15:0] data_out,
  input wire logic        data_oe_hi,
  input wire logic        data_oe_lo,
  // init and protection
  input wire logic        init_done_nv,
  input wire logic        init_done_set,
  input wire logic        flash_id_req,
  input wire logic [3:0]  zone_enable,
  input wire logic        media_access_ok,
  input wire logic [1:0]  wl_group
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // six cycles cover the select sync stages and the registered enables
  a_idle_bus_free: assert property (
    (cmd_block_select_n && alt_block_select_n) [*6] |-> !data_oe_lo)
    else $error("bus driven with no select");
  a_both_sel_none: assert property (
    (!cmd_block_select_n && !alt_block_select_n) [*6] |-> !data_oe_lo)
    else $error("bus driven with both selects");
  a_hi_needs_lo: assert property (data_oe_hi |-> data_oe_lo)
    else $error("upper lane driven alone");
  a_oe_from_read: assert property (
    $rose(data_oe_lo) |-> !$past(io_read_strobe_n))
    else $error("drive without read strobe");
  a_read_data_hold: assert property (
    !io_read_strobe_n [*6] ##1 !io_read_strobe_n |-> $stable(data_out))
    else $error("read data moved under strobe");
  a_nv_skip_scan: assert property (init_done_nv |-> !flash_id_req)
    else $error("media scan after init done");
  a_init_set_pulse: assert property (init_done_set |=> !init_done_set)
    else $error("init flag set twice");
  a_wl_from_write: assert property (
    $changed(wl_group) |-> !io_write_strobe_n)
    else $error("group moved without write");
  // access is only granted after init; once open with no zone, it stays open
  a_open_no_zone: assert property (
    zone_enable == 4'h0 && $past(media_access_ok) |-> media_access_ok)
    else $error("access refused with no zone");
  // main scenarios reached
  c_read_answer: cover property ($rose(data_oe_lo));
  c_init_done: cover property (init_done_set);
  c_unlock: cover property ($rose(media_access_ok) && zone_enable != 4'h0);
endmodule // ahp_port_properties

bind ahp_port ahp_port_properties u_props (
  .clk_sys(clk_sys), .rst(rst), .cmd_block_select_n(cmd_block_select_n),
  .alt_block_select_n(alt_block_select_n),
  .io_read_strobe_n(io_read_strobe_n), .io_write_strobe_n(io_write_strobe_n),
  .data_out(data_out), .data_oe_hi(data_oe_hi), .data_oe_lo(data_oe_lo),
  .init_done_nv(init_done_nv), .init_done_set(init_done_set),
  .flash_id_req(flash_id_req), .zone_enable(zone_enable),
  .media_access_ok(media_access_ok), .wl_group(wl_group));
`default_nettype wire

// file: ahp_host_model.sv
// host controller model issuing task-file read and write cycles
// assumes clk_sys paces the host; strobes held 7 cycles, gaps of at least 6
`default_nettype none
module ahp_host_model (
  // clock
  input  wire logic        clk_sys,
  // task-file bus toward the device
  output logic             cmd_block_select_n,
  output logic             alt_block_select_n,
  output logic [2:0]       addr,
  output logic             io_read_strobe_n,
  output logic             io_write_strobe_n,
  output logic [15:0]      data_in,
  // device read data and lane enables
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe_hi,
  input  wire logic        data_oe_lo
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus: nothing selected, data lines at a firm level
  initial begin
    {cmd_block_select_n, alt_block_select_n} = 2'b11;
    {io_read_strobe_n, io_write_strobe_n} = 2'b11;
    addr = 3'h0;
    data_in = 16'hFFFF;
  end
  // one whole cycle; s holds the two select levels {cmd, alt}
  task automatic cyc(input logic w, input logic [1:0] s,
                     input logic [2:0] a, input logic [15:0] d,
                     output logic [15:0] q, output logic [1:0] oe);
    @(posedge clk_sys);
    {cmd_block_select_n, alt_block_select_n} <= s;
    addr <= a;
    data_in <= d;
    io_write_strobe_n <= !w;
    io_read_strobe_n <= w;
    // long hold so the device's sync stages see a steady request
    repeat (7) @(posedge clk_sys);
    q = data_out;
    oe = {data_oe_hi, data_oe_lo};
    {cmd_block_select_n, alt_block_select_n} <= 2'b11;
    {io_read_strobe_n, io_write_strobe_n} <= 2'b11;
    // released lines stay at a valid level but drop the old value
    data_in <= ~d;
    repeat (5) @(posedge clk_sys);
  endtask
endmodule // ahp_host_model
`default_nettype wire

// file: tb.sv
// testbench for the ata host port: host model plus flash id responder
// assumes the checker is bound from its own file; init shortened to 100
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
`define CHK(n, e, g) cmp_count++; if ((g) !== (e)) begin \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); miscompares++; end
  localparam logic [1:0] CMD = 2'b01; // selects as {cmd, alt}
  localparam logic [1:0] ALT = 2'b10;
  localparam logic [7:0] SPC [3] = '{ahp_pkg::CMD_IDLE_ALT,
    ahp_pkg::CMD_SLEEP_ALT, ahp_pkg::CMD_PROTECT_PD};
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        init_done_nv = 1'b0;
  logic        known = 1'b1;        // flash parts answer as recognised
  logic        flash_id_valid = 1'b0;
  logic        flash_id_known = 1'b0;
  logic [3:0]  zone_enable = 4'h0;
  logic [15:0] q;
  logic [1:0]  oe;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          req_cnt = 0;         // cycles with an id request seen
  int          sclk_cnt = 0;        // serial clock transitions
  logic [7:0]  sdo_shift = 8'h00;   // bits seen on the serial data line
  int          n;
  wire logic cs_n, alt_n, rd_n, wr_n, init_done_set, flash_id_req;
  wire logic oe_hi, oe_lo, media_access_ok, sclk, sdo;
  wire logic [2:0]  addr;
  wire logic [15:0] din, dout;
  wire logic [1:0]  wl_group;
  always #5 clk_sys = ~clk_sys;
  // flash parts answer an id request one cycle later
  always @(posedge clk_sys) begin
    flash_id_valid <= flash_id_req;
    flash_id_known <= known;
    if (flash_id_req === 1'b1) req_cnt++;
  end
  always @(sclk) sclk_cnt++;
  // data is settled while the serial clock is high, so take it on its fall
  always @(negedge sclk) sdo_shift <= {sdo_shift[6:0], sdo};
  // hang guard, well above the expected run length
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  ahp_host_model h (.clk_sys(clk_sys), .cmd_block_select_n(cs_n),
    .alt_block_select_n(alt_n), .addr(addr), .io_read_strobe_n(rd_n),
    .io_write_strobe_n(wr_n), .data_in(din), .data_out(dout),
    .data_oe_hi(oe_hi), .data_oe_lo(oe_lo));
  ahp_port #(.INIT_CYCLES(100)) uut (.clk_sys(clk_sys), .rst(rst),
    .cmd_block_select_n(cs_n), .alt_block_select_n(alt_n), .addr(addr),
    .io_read_strobe_n(rd_n), .io_write_strobe_n(wr_n), .data_in(din),
    .data_out(dout), .data_oe_hi(oe_hi), .data_oe_lo(oe_lo),
    .init_done_nv(init_done_nv), .init_done_set(init_done_set),
    .flash_id_req(flash_id_req), .flash_id_valid(flash_id_valid),
    .flash_id_known(flash_id_known), .zone_enable(zone_enable),
    .zone_hidden(4'h0), .access_zone(2'h0), .zone_password(16'hA5C3),
    .media_access_ok(media_access_ok), .wl_group(wl_group),
    .serial_mfg_clock(sclk), .serial_mfg_data_out(sdo),
    .serial_mfg_data_in(1'b0));
  task automatic rd(input logic [1:0] s, input logic [2:0] a);
    h.cyc(1'b0, s, a, 16'h0000, q, oe);
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    logic [15:0] x;
    logic [1:0]  y;
    h.cyc(1'b1, CMD, a, d, x, y);
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rst_pulse();
    rst <= 1'b1;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
  endtask
  // main sequence
  initial begin
    rst_pulse();
    repeat (4) @(posedge clk_sys);
    rd(CMD, ahp_pkg::ADDR_COMMAND);
    `CHK("bsy_init", 1'b1, q[ahp_pkg::STAT_BSY])
    for (int i = 0; i < 2000 && init_done_set !== 1'b1; i++)
      @(negedge clk_sys);
    `CHK("init_set", 1'b1, init_done_set)
    `CHK("id_scan", 1'b1, req_cnt > 0)
    repeat (4) @(posedge clk_sys);
    rd(CMD, ahp_pkg::ADDR_COMMAND);
    `CHK("bsy_done", 1'b0, q[ahp_pkg::STAT_BSY])
    rd(CMD, ahp_pkg::ADDR_DATA_PORT);
    `CHK("oe_16", 2'b11, oe)
    rd(ALT, ahp_pkg::ADDR_CTRL_ALT);
    `CHK("oe_alt", 2'b01, oe)
    `CHK("alt_bsy", 1'b0, q[ahp_pkg::STAT_BSY])
    rd(2'b11, ahp_pkg::ADDR_COMMAND);
    `CHK("oe_none", 2'b00, oe)
    rd(2'b00, ahp_pkg::ADDR_COMMAND);
    `CHK("oe_both", 2'b00, oe)
    for (int g = 3; g >= 0; g--) begin
      wr(ahp_pkg::ADDR_SECTOR_COUNT, 16'(g));
      `CHK("wl_group", 2'(g), wl_group)
    end
    // a full word through the data port, then byte mode and back
    wr(ahp_pkg::ADDR_DATA_PORT, 16'h3C5A);
    rd(CMD, ahp_pkg::ADDR_DATA_PORT);
    `CHK("data16", 16'h3C5A, q)
    wr(ahp_pkg::ADDR_FEATURES, {8'h00, ahp_pkg::FEAT_EN_8BIT});
    wr(ahp_pkg::ADDR_COMMAND, {8'h00, ahp_pkg::CMD_SET_FEATURES});
    rd(CMD, ahp_pkg::ADDR_DATA_PORT);
    `CHK("hi_byte_8", 8'hFF, q[15:8])
    `CHK("lo_byte_8", 8'h5A, q[7:0])
    wr(ahp_pkg::ADDR_FEATURES, {8'h00, ahp_pkg::FEAT_DIS_8BIT});
    wr(ahp_pkg::ADDR_COMMAND, {8'h00, ahp_pkg::CMD_SET_FEATURES});
    rd(CMD, ahp_pkg::ADDR_DATA_PORT);
    `CHK("oe_back16", 2'b11, oe)
    foreach (SPC[i]) begin
      wr(ahp_pkg::ADDR_COMMAND, {8'h00, SPC[i]});
      rd(CMD, ahp_pkg::ADDR_COMMAND);
      `CHK("spc_err", 1'b0, q[ahp_pkg::STAT_ERR])
    end
    repeat (2) @(negedge clk_sys);
    `CHK("open", 1'b1, media_access_ok)
    @(posedge clk_sys);
    zone_enable <= 4'h1;
    repeat (2) @(negedge clk_sys);
    `CHK("locked", 1'b0, media_access_ok)
    // a wrong password first, then the right one
    wr(ahp_pkg::ADDR_DATA_PORT, 16'h1111);
    wr(ahp_pkg::ADDR_COMMAND, {8'h00, ahp_pkg::CMD_SEC_UNLOCK});
    `CHK("bad_pw", 1'b0, media_access_ok)
    wr(ahp_pkg::ADDR_DATA_PORT, 16'hA5C3);
    wr(ahp_pkg::ADDR_COMMAND, {8'h00, ahp_pkg::CMD_SEC_UNLOCK});
    `CHK("good_pw", 1'b1, media_access_ok)
    // later power-up: init already recorded
    init_done_nv <= 1'b1;
    n = req_cnt;
    rst_pulse();
    repeat (10) @(posedge clk_sys);
    rd(CMD, ahp_pkg::ADDR_COMMAND);
    `CHK("bsy_skip", 1'b0, q[ahp_pkg::STAT_BSY])
    `CHK("no_rescan", 1'b1, req_cnt == n)
    // unknown flash parts: init fails and reports on the serial link
    init_done_nv <= 1'b0;
    known <= 1'b0;
    rst_pulse();
    n = sclk_cnt;
    repeat (400) @(posedge clk_sys);
    rd(CMD, ahp_pkg::ADDR_COMMAND);
    `CHK("fail_stat", 8'h01, q[7:0])
    repeat (1200) @(posedge clk_sys);
    `CHK("mfg_clock", 1'b1, sclk_cnt > n)
    `CHK("mfg_code", 8'(ahp_pkg::ST_FAIL), sdo_shift)
    end_sim();
  end
endmodule // tb
`default_nettype wire
